// ===== src/gcrb_pkg.sv
// package: index map, field layout and reset values of the global config bank
package gcrb_pkg;
  // register indices on the data port
  localparam logic [7:0] IDX_SOFT_RST = 8'h02;
  localparam logic [7:0] IDX_LD_SEL = 8'h07;
  localparam logic [7:0] IDX_CHIP_ID = 8'h20;
  localparam logic [7:0] IDX_CHIP_REV = 8'h21;
  localparam logic [7:0] IDX_PWR = 8'h22;
  localparam logic [7:0] IDX_RSVD_RW = 8'h23;
  localparam logic [7:0] IDX_OSC = 8'h24;
  localparam logic [7:0] IDX_ADDR_LO = 8'h26;
  localparam logic [7:0] IDX_ADDR_HI = 8'h27;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  // field positions
  localparam int SOFT_RST_BIT = 0;
  localparam int PWR_UART1_BIT = 4;
  localparam int PWR_UART2_BIT = 5;
  localparam int OSC_PLL_OFF_BIT = 1;
  localparam int OSC_STATE_LSB = 2;
  localparam int OSC_QUAL16_BIT = 6;
  localparam int ACT_BIT = 0;
  localparam logic [1:0] OSC_STOPPED = 2'b11;
  // implemented-bit masks and reset values
  localparam logic [7:0] PWR_MASK = 8'h30;
  localparam logic [7:0] OSC_MASK = 8'h4e;
  localparam logic [7:0] OSC_RST = 8'h44;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] ADDR_LO_STRAP0 = 8'h2e;
  localparam logic [7:0] ADDR_LO_STRAP1 = 8'h4e;
  localparam logic [7:0] ADDR_HI_STRAP0 = 8'h16;
  localparam logic [7:0] ADDR_HI_STRAP1 = 8'h00;
  // logical devices that carry an activate bit
  localparam logic [7:0] LD_UART1 = 8'h04;
  localparam logic [7:0] LD_UART2 = 8'h05;
  // host command registers (AXI4-Lite byte addresses)
  localparam logic [7:0] HREG_PORT_ADDR = 8'h00;
  localparam logic [7:0] HREG_WDATA = 8'h04;
  localparam logic [7:0] HREG_CTRL = 8'h08;
  localparam logic [7:0] HREG_STATUS = 8'h0c;
  localparam int CTRL_GO_WR_BIT = 0;
  localparam int CTRL_GO_RD_BIT = 1;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
  // cycles the host waits for an acknowledge before giving up
  localparam logic [2:0] NO_RESP_CYC = 3'd4;
  localparam logic [7:0] FLOAT_BYTE = 8'hff;
endpackage

// ===== src/gcrb_io_if.sv
// interface: index/data port I/O cycles between host and config bank
`timescale 1ns/1ps
interface gcrb_io_if;
  logic ioStb;
  logic ioWrite;
  logic [15:0] ioAddr;
  logic [7:0] ioWdata;
  logic ioAck;
  logic [7:0] ioRdata;
  modport dev (
    input ioStb,
    input ioWrite,
    input ioAddr,
    input ioWdata,
    output ioAck,
    output ioRdata
  );
  modport host (
    output ioStb,
    output ioWrite,
    output ioAddr,
    output ioWdata,
    input ioAck,
    input ioRdata
  );
endinterface

// ===== src/gcrb_device.sv
// module: chip-level configuration register bank behind an index/data port pair
`timescale 1ns/1ps
module gcrb_device
  import gcrb_pkg::*;
#(
  parameter logic [7:0] CHIP_ID = 8'h5a, // arbitrary value
  parameter logic [7:0] CHIP_REV = 8'h01 // arbitrary value
)
(
  // clock and VCC power-on reset
  input wire logic clk,
  input wire logic arst_n,
  // port cycles from the host
  gcrb_io_if.dev io,
  // further resets, synchronous levels
  input wire logic pciRst,
  input wire logic vtrRst,
  // configuration mode from the entry/exit logic
  input wire logic cfgModeActive,
  // address straps
  input wire logic addressStrapLow,
  input wire logic addressStrapHigh,
  // serial port pin-function selection
  input wire logic [1:0] uartPinSelected,
  // serial port control
  output logic [1:0] uartPowered,
  output logic [1:0] uartTristate,
  // clocking control
  output logic pllOff,
  output logic oscRunning,
  output logic baudRateClockEnable,
  // address qualification and selection
  output logic addrQual16,
  output logic [7:0] logicalDevice,
  output logic [15:0] configPortBase,
  // decode helper for other I/O decoders
  input wire logic [15:0] decodeAddr,
  input wire logic [15:0] decodeBase,
  output logic decodeHit
);

  function automatic logic addrMatch(input logic [15:0] a, input logic [15:0] b,
                                     input logic q16);
    addrMatch = q16 ? (a == b) : (a[11:0] == b[11:0]);
  endfunction

  logic [7:0] index_r;
  logic [7:0] ldSel_r;
  logic [7:0] pwr_r;
  logic [1:0] act_r;
  logic [7:0] rsvd_r;
  logic [7:0] osc_r;
  logic [6:0] addrLoPend_r;
  logic [6:0] addrLo_r;
  logic [7:0] addrHi_r;
  logic addrLoaded_r;
  logic ack_r;
  logic [7:0] rdata_r;
  logic [7:0] readVal;

  wire [15:0] baseIndex = {addrHi_r, addrLo_r, 1'b0};
  wire [15:0] baseData = baseIndex + 16'h0001;
  // no claim at all outside configuration mode
  wire hitIndex = cfgModeActive && addrMatch(io.ioAddr, baseIndex, addrQual16);
  wire hitData = cfgModeActive && addrMatch(io.ioAddr, baseData, addrQual16);
  wire idxWr = io.ioStb && io.ioWrite && hitIndex;
  wire dataWr = io.ioStb && io.ioWrite && hitData;
  wire [7:0] wdat = io.ioWdata;
  wire wrLdSel = dataWr && (index_r == IDX_LD_SEL);
  wire wrPwr = dataWr && (index_r == IDX_PWR);
  wire wrRsvd = dataWr && (index_r == IDX_RSVD_RW);
  wire wrOsc = dataWr && (index_r == IDX_OSC);
  wire wrAddrLo = dataWr && (index_r == IDX_ADDR_LO);
  wire wrAddrHi = dataWr && (index_r == IDX_ADDR_HI);
  wire wrAct = dataWr && (index_r == IDX_ACTIVATE);
  // the control bit is never stored, so it reads back zero on its own
  wire softRst = dataWr && (index_r == IDX_SOFT_RST) && wdat[SOFT_RST_BIT];
  wire hwRst = pciRst || vtrRst;
  wire softGrpRst = hwRst || softRst;
  wire strapLoad = !addrLoaded_r || pciRst;
  wire [7:0] strapLo = addressStrapLow ? ADDR_LO_STRAP1 : ADDR_LO_STRAP0;
  wire [7:0] strapHi = addressStrapHigh ? ADDR_HI_STRAP1 : ADDR_HI_STRAP0;
  wire actSel = (ldSel_r == LD_UART1) ? act_r[0] :
                (ldSel_r == LD_UART2) ? act_r[1] : 1'b0;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      index_r <= BYTE_RST;
    else if (hwRst)
      index_r <= BYTE_RST;
    else if (idxWr)
      index_r <= wdat;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ldSel_r <= BYTE_RST;
    else if (softGrpRst)
      ldSel_r <= BYTE_RST;
    else if (wrLdSel)
      ldSel_r <= wdat;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pwr_r <= BYTE_RST;
    else if (softGrpRst)
      pwr_r <= BYTE_RST;
    else if (wrPwr)
      pwr_r <= wdat & PWR_MASK;
  end

  // one activate bit per serial-port logical device
  for (genvar i = 0; i < 2; i++)
  begin : g_act
    localparam logic [7:0] MY_LD = (i == 0) ? LD_UART1 : LD_UART2;
    always_ff @(posedge clk or negedge arst_n)
    begin
      if (!arst_n)
        act_r[i] <= 1'b0;
      else if (softGrpRst)
        act_r[i] <= 1'b0;
      else if (wrAct && (ldSel_r == MY_LD))
        act_r[i] <= wdat[ACT_BIT];
    end
  end

  // 0x23 and 0x24 survive a soft reset
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rsvd_r <= BYTE_RST;
    else if (hwRst)
      rsvd_r <= BYTE_RST;
    else if (wrRsvd)
      rsvd_r <= wdat;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      osc_r <= OSC_RST;
    else if (hwRst)
      osc_r <= OSC_RST;
    else if (wrOsc)
      osc_r <= wdat & OSC_MASK;
  end

  // straps cannot be sampled under the asynchronous reset, so the first
  // clocked cycle after release loads them
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      addrLoaded_r <= 1'b0;
    else
      addrLoaded_r <= 1'b1;
  end

  // low byte is held pending so the port does not move half way
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      addrLoPend_r <= 7'h00;
    else if (strapLoad)
      addrLoPend_r <= strapLo[7:1];
    else if (wrAddrLo)
      addrLoPend_r <= wdat[7:1];
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      addrLo_r <= 7'h00;
    else if (strapLoad)
      addrLo_r <= strapLo[7:1];
    else if (wrAddrHi)
      addrLo_r <= addrLoPend_r;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      addrHi_r <= 8'h00;
    else if (strapLoad)
      addrHi_r <= strapHi;
    else if (wrAddrHi)
      addrHi_r <= wdat;
  end

  always_comb
  begin
    readVal = 8'h00;
    case (index_r)
      IDX_LD_SEL: readVal = ldSel_r;
      IDX_CHIP_ID: readVal = CHIP_ID;
      IDX_CHIP_REV: readVal = CHIP_REV;
      IDX_PWR: readVal = pwr_r;
      IDX_RSVD_RW: readVal = rsvd_r;
      IDX_OSC: readVal = osc_r;
      IDX_ADDR_LO: readVal = {addrLoPend_r, 1'b0};
      IDX_ADDR_HI: readVal = addrHi_r;
      IDX_ACTIVATE: readVal = {7'h00, actSel};
      default: readVal = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack_r <= 1'b0;
      rdata_r <= 8'h00;
    end
    else
    begin
      ack_r <= io.ioStb && (hitIndex || hitData);
      if (io.ioStb && !io.ioWrite && hitIndex)
        rdata_r <= index_r;
      else if (io.ioStb && !io.ioWrite && hitData)
        rdata_r <= readVal;
    end
  end

  assign io.ioAck = ack_r;
  assign io.ioRdata = rdata_r;

  assign uartPowered[0] = pwr_r[PWR_UART1_BIT] && act_r[0];
  assign uartPowered[1] = pwr_r[PWR_UART2_BIT] && act_r[1];
  assign uartTristate = ~uartPowered & uartPinSelected;
  assign pllOff = osc_r[OSC_PLL_OFF_BIT];
  assign oscRunning = osc_r[OSC_STATE_LSB +: 2] != OSC_STOPPED;
  assign baudRateClockEnable = oscRunning;
  assign addrQual16 = osc_r[OSC_QUAL16_BIT];
  assign logicalDevice = ldSel_r;
  assign configPortBase = baseIndex;
  assign decodeHit = addrMatch(decodeAddr, decodeBase, addrQual16);

endmodule // gcrb_device

// ===== src/gcrb_host.sv
// module: host that turns AXI4-Lite commands into index/data port cycles
`timescale 1ns/1ps
module gcrb_host
  import gcrb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // port cycles toward the bank
  gcrb_io_if.host io
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_STROBE = 3'b010,
    ST_WAIT = 3'b100
  } gcrb_hst_state_t;

  gcrb_hst_state_t state_r;
  logic [15:0] portAddr_r;
  logic [7:0] wdata_r;
  logic isWrite_r;
  logic [2:0] waitCnt_r;
  logic noResp_r;
  logic [7:0] rdata_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] axiRdata_r;

  wire wrTake = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  wire rdTake = s_axi_arvalid && !rvalid_r;
  wire busy = state_r != ST_IDLE;
  wire wrMapped = (s_axi_awaddr == HREG_PORT_ADDR) || (s_axi_awaddr == HREG_WDATA) ||
                  (s_axi_awaddr == HREG_CTRL) || (s_axi_awaddr == HREG_STATUS);
  wire rdMapped = (s_axi_araddr == HREG_PORT_ADDR) || (s_axi_araddr == HREG_WDATA) ||
                  (s_axi_araddr == HREG_CTRL) || (s_axi_araddr == HREG_STATUS);
  // commands and operand changes are refused while a cycle is in flight
  wire ctrlWr = wrTake && !busy && (s_axi_awaddr == HREG_CTRL) && s_axi_wstrb[0];
  wire goWr = ctrlWr && s_axi_wdata[CTRL_GO_WR_BIT];
  wire goRd = ctrlWr && !s_axi_wdata[CTRL_GO_WR_BIT] && s_axi_wdata[CTRL_GO_RD_BIT];
  wire addrWr = wrTake && !busy && (s_axi_awaddr == HREG_PORT_ADDR);
  wire datWr = wrTake && !busy && (s_axi_awaddr == HREG_WDATA) && s_axi_wstrb[0];
  wire timeout = waitCnt_r == (NO_RESP_CYC - 3'd1);
  wire [31:0] status = {16'h0000, rdata_r, 6'h00, noResp_r, busy};
  wire [31:0] rdMux = (s_axi_araddr == HREG_PORT_ADDR) ? {16'h0000, portAddr_r} :
                      (s_axi_araddr == HREG_WDATA) ? {24'h000000, wdata_r} :
                      (s_axi_araddr == HREG_STATUS) ? status : 32'h00000000;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      portAddr_r <= 16'h0000;
    else if (addrWr)
    begin
      if (s_axi_wstrb[0])
        portAddr_r[7:0] <= s_axi_wdata[7:0];
      if (s_axi_wstrb[1])
        portAddr_r[15:8] <= s_axi_wdata[15:8];
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      wdata_r <= 8'h00;
    else if (datWr)
      wdata_r <= s_axi_wdata[7:0];
  end

  // software issues the index write before each data access, and the low
  // relocation byte before the high one; the host keeps them in order given
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= ST_IDLE;
      isWrite_r <= 1'b0;
      waitCnt_r <= 3'd0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
          if (goWr || goRd)
          begin
            state_r <= ST_STROBE;
            isWrite_r <= goWr;
          end
        ST_STROBE:
        begin
          state_r <= ST_WAIT;
          waitCnt_r <= 3'd0;
        end
        ST_WAIT:
          if (io.ioAck || timeout)
            state_r <= ST_IDLE;
          else
            waitCnt_r <= waitCnt_r + 3'd1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      noResp_r <= 1'b0;
      rdata_r <= 8'h00;
    end
    else if (state_r == ST_STROBE)
      noResp_r <= 1'b0;
    else if (state_r == ST_WAIT && io.ioAck)
    begin
      if (!isWrite_r)
        rdata_r <= io.ioRdata;
    end
    else if (state_r == ST_WAIT && timeout)
    begin
      noResp_r <= 1'b1;
      if (!isWrite_r)
        rdata_r <= FLOAT_BYTE;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= AXI_OKAY;
    end
    else if (wrTake)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= wrMapped ? AXI_OKAY : AXI_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rvalid_r <= 1'b0;
      rresp_r <= AXI_OKAY;
      axiRdata_r <= 32'h00000000;
    end
    else if (rdTake)
    begin
      rvalid_r <= 1'b1;
      rresp_r <= rdMapped ? AXI_OKAY : AXI_SLVERR;
      axiRdata_r <= rdMux;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  assign s_axi_awready = wrTake;
  assign s_axi_wready = wrTake;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = rdTake;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = axiRdata_r;
  assign io.ioStb = state_r == ST_STROBE;
  assign io.ioWrite = isWrite_r;
  assign io.ioAddr = portAddr_r;
  assign io.ioWdata = wdata_r;

endmodule // gcrb_host

// ===== dv/gcrb_props.sv
// checker: port-cycle timing, port relocation and decode qualification
`timescale 1ns/1ps
module gcrb_props
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // port link
  input wire logic ioStb,
  input wire logic ioWrite,
  input wire logic [15:0] ioAddr,
  input wire logic ioAck,
  input wire logic [7:0] ioRdata,
  // device side
  input wire logic cfgModeActive,
  input wire logic pciRst,
  input wire logic addrQual16,
  input wire logic [15:0] configPortBase,
  input wire logic [15:0] decodeAddr,
  input wire logic [15:0] decodeBase,
  input wire logic decodeHit
);
  logic [15:0] dataPort;
  logic portHit;
  logic decMatch;
  assign dataPort = configPortBase + 16'h0001;
  // 12-bit mode ignores the top nibble on both ports
  assign portHit = addrQual16 ? (ioAddr == configPortBase || ioAddr == dataPort)
    : (ioAddr[11:0] == configPortBase[11:0] || ioAddr[11:0] == dataPort[11:0]);
  assign decMatch = addrQual16 ? decodeAddr == decodeBase : decodeAddr[11:0] == decodeBase[11:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_ack_iff_claim: assert property (ioStb |=> ioAck == $past(cfgModeActive && portHit))
    else $error("ack does not follow claim");
  chk_ack_one_pulse: assert property (ioAck |=> !ioAck)
    else $error("ack longer than one cycle");
  chk_ack_has_cause: assert property (ioAck |-> $past(ioStb))
    else $error("ack without strobe");
  chk_rdata_holds: assert property (!(ioAck && $past(ioStb) && !$past(ioWrite)) |-> $stable(ioRdata))
    else $error("read data moved without read");
  chk_stb_single: assert property (ioStb |=> !ioStb)
    else $error("strobe longer than one cycle");
  chk_base_moves: assert property ($changed(configPortBase) |-> (ioAck && $past(ioWrite))
    || $past(pciRst) || !$past(arst_n) || !$past(arst_n, 2))
    else $error("port base moved without cause");
  chk_base_even: assert property (configPortBase[0] == 1'b0)
    else $error("port base odd");
  chk_decode_qual: assert property (decodeHit == decMatch)
    else $error("decode hit wrong");
  cover property (ioStb && !cfgModeActive);
  cover property ($changed(configPortBase) && ioAck);
  cover property (ioStb && portHit && !addrQual16 && ioAddr[15:12] != configPortBase[15:12]);
endmodule // gcrb_props

// ===== dv/global_config_register_bank_test.sv
// testbench: AXI4-Lite commands reach the config bank over the port link
`timescale 1ns/1ps
module global_config_register_bank_test
  import gcrb_pkg::*;
;
  localparam logic [7:0] ID = 8'h5a; // arbitrary value
  localparam logic [7:0] REV = 8'h01; // arbitrary value
  logic clk = 1'b0, arst_n = 1'b0, pciRst = 1'b0, vtrRst = 1'b0, cfgModeActive = 1'b1;
  logic strapLo = 1'b0, strapHi = 1'b0;
  logic [1:0] pinSel = 2'b00;
  logic [15:0] decodeAddr = 16'h0000, decodeBase = 16'h0000;
  logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
  logic [31:0] wData = 32'h0;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid, pllOff, oscRunning, baudEn, addrQual16, decodeHit;
  logic [1:0] rResp, bResp, uartPowered, uartTristate;
  logic [7:0] ldOut;
  logic [31:0] rData;
  logic [15:0] configPortBase, base;
  logic [15:0] tbl[$];
  logic [33:0] expQ[$];
  int mismatches = 0, testsRun = 0;
  gcrb_io_if gcrb_io_if_i();
  gcrb_device #(.CHIP_ID(ID), .CHIP_REV(REV)) gcrb_device_i (.clk(clk), .arst_n(arst_n),
    .io(gcrb_io_if_i.dev), .pciRst(pciRst), .vtrRst(vtrRst), .cfgModeActive(cfgModeActive),
    .addressStrapLow(strapLo), .addressStrapHigh(strapHi), .uartPinSelected(pinSel),
    .uartPowered(uartPowered), .uartTristate(uartTristate), .pllOff(pllOff),
    .oscRunning(oscRunning), .baudRateClockEnable(baudEn), .addrQual16(addrQual16),
    .logicalDevice(ldOut), .configPortBase(configPortBase), .decodeAddr(decodeAddr),
    .decodeBase(decodeBase), .decodeHit(decodeHit));
  gcrb_host gcrb_host_i (.clk(clk), .arst_n(arst_n), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .io(gcrb_io_if_i.host));
  gcrb_props gcrb_props_i (.clk(clk), .arst_n(arst_n), .ioStb(gcrb_io_if_i.ioStb),
    .ioWrite(gcrb_io_if_i.ioWrite), .ioAddr(gcrb_io_if_i.ioAddr), .ioAck(gcrb_io_if_i.ioAck),
    .ioRdata(gcrb_io_if_i.ioRdata), .cfgModeActive(cfgModeActive), .pciRst(pciRst),
    .addrQual16(addrQual16), .configPortBase(configPortBase), .decodeAddr(decodeAddr),
    .decodeBase(decodeBase), .decodeHit(decodeHit));
  initial forever #2.5 clk = ~clk;
  task automatic cmp(input string what, input logic [33:0] exp, input logic [33:0] got);
    testsRun++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // read results are matched at the negedge before the handshake edge
  always @(negedge clk)
    if (rValid === 1'b1 && rReady === 1'b1)
      cmp("axi read", expQ.size() ? expQ.pop_front() : 'x, {rResp, rData});
  // handshakes are seen at the negedge, so the release lands right after the taking edge
  task automatic axWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do @(negedge clk); while (!(awReady === 1'b1 && wReady === 1'b1));
    @(posedge clk);
    awValid <= 1'b0;
    wValid <= 1'b0;
    do @(negedge clk); while (bValid !== 1'b1);
    // only the four word-aligned host registers answer okay
    cmp("axi bresp", 34'((a[7:4] == 4'h0 && a[1:0] == 2'b00) ? AXI_OKAY : AXI_SLVERR),
      34'(bResp));
    @(posedge clk);
    bReady <= 1'b0;
  endtask
  task automatic axRd(input logic [7:0] a, input logic [33:0] exp);
    expQ.push_back(exp);
    @(posedge clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do @(negedge clk); while (arReady !== 1'b1);
    @(posedge clk);
    arValid <= 1'b0;
    do @(negedge clk); while (rValid !== 1'b1);
    @(posedge clk);
    rReady <= 1'b0;
  endtask
  // one port cycle; eight cycles cover the longest no-answer case
  task automatic port(input logic [15:0] a, input logic wr, input logic [7:0] d);
    axWr(HREG_PORT_ADDR, {16'h0, a});
    if (wr) axWr(HREG_WDATA, {24'h0, d});
    axWr(HREG_CTRL, wr ? 32'h1 : 32'h2);
    repeat (8) @(posedge clk);
  endtask
  task automatic wrReg(input logic [7:0] i, input logic [7:0] v);
    port(base, 1'b1, i);
    port(base + 16'h1, 1'b1, v);
  endtask
  task automatic chkReg(input logic [7:0] i, input logic [7:0] v);
    port(base, 1'b1, i);
    port(base + 16'h1, 1'b0, 8'h0);
    axRd(HREG_STATUS, {AXI_OKAY, 16'h0, v, 8'h0});
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #100000;
    mismatches++;
    close_out();
  end
  initial
  begin
    void'($urandom(32'hd0fb));
    {strapHi, strapLo} <= 2'($urandom);
    pinSel <= 2'($urandom);
    decodeBase <= 16'($urandom);
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    base = {strapHi ? ADDR_HI_STRAP1 : ADDR_HI_STRAP0, strapLo ? ADDR_LO_STRAP1 : ADDR_LO_STRAP0};
    cmp("base", 34'(base), 34'(configPortBase));
    tbl = '{{8'h20, ID}, {8'h21, REV}, 16'h2444, 16'h2200, 16'h0700, 16'h2300, 16'h0200,
      16'h0000, 16'h2800, {8'h26, base[7:0]}, {8'h27, base[15:8]}};
    foreach (tbl[k]) chkReg(tbl[k][15:8], tbl[k][7:0]);
    tbl = '{16'h22ff, 16'h24ff, 16'h01ff, 16'h28ff, 16'ha200, 16'h20ff};
    foreach (tbl[k]) wrReg(tbl[k][15:8], tbl[k][7:0]);
    tbl = '{16'h2230, 16'h244e, 16'h0100, 16'h2800, {8'h20, ID}};
    foreach (tbl[k]) chkReg(tbl[k][15:8], tbl[k][7:0]);
    $display("test reset values and masks done");
    for (int c = 0; c < 8; c++)
    begin
      wrReg(IDX_OSC, {1'b0, ~c[2], 2'b00, c[1:0], c[2], 1'b0});
      @(posedge clk);
      decodeAddr <= decodeBase ^ {c[1:0], 14'h0};
      @(negedge clk);
      cmp("osc",
        34'({c[2], c[1:0] != 2'b11, c[1:0] != 2'b11, ~c[2], c[2] || c[1:0] == 2'b00}),
        34'({pllOff, oscRunning, baudEn, addrQual16, decodeHit}));
    end
    $display("test oscillator codes done");
    wrReg(IDX_PWR, 8'h30);
    wrReg(IDX_RSVD_RW, 8'h5a);
    wrReg(IDX_LD_SEL, LD_UART1);
    wrReg(IDX_ACTIVATE, 8'h01);
    chkReg(IDX_LD_SEL, LD_UART1);
    wrReg(IDX_LD_SEL, LD_UART2);
    cmp("ld", 34'(LD_UART2), 34'(ldOut));
    chkReg(IDX_ACTIVATE, 8'h00);
    cmp("uart", 34'({2'b01, 2'b10 & pinSel}), 34'({uartPowered, uartTristate}));
    wrReg(IDX_ACTIVATE, 8'h01);
    wrReg(IDX_PWR, 8'h10);
    cmp("uart", 34'({2'b01, 2'b10 & pinSel}), 34'({uartPowered, uartTristate}));
    wrReg(IDX_SOFT_RST, 8'h01);
    cmp("uart", 34'(2'b00), 34'(uartPowered));
    // the oscillator byte keeps the last loop value (code 7) across a soft reset
    tbl = '{16'h2200, 16'h0700, 16'h235a, 16'h0200, 16'h240e};
    foreach (tbl[k]) chkReg(tbl[k][15:8], tbl[k][7:0]);
    $display("test device select and soft reset done");
    wrReg(IDX_ADDR_LO, 8'h61);
    cmp("base", 34'(base), 34'(configPortBase));
    chkReg(IDX_ADDR_LO, 8'h60);
    port(base, 1'b0, 8'h0);
    axRd(HREG_STATUS, {AXI_OKAY, 16'h0, IDX_ADDR_LO, 8'h0});
    wrReg(IDX_ADDR_HI, 8'h0a);
    base = 16'h0a60;
    cmp("base", 34'(base), 34'(configPortBase));
    @(posedge clk);
    vtrRst <= 1'b1;
    @(posedge clk);
    vtrRst <= 1'b0;
    chkReg(IDX_OSC, OSC_RST);
    cmp("base", 34'(base), 34'(configPortBase));
    @(posedge clk);
    pciRst <= 1'b1;
    @(posedge clk);
    pciRst <= 1'b0;
    @(negedge clk);
    base = {strapHi ? ADDR_HI_STRAP1 : ADDR_HI_STRAP0, strapLo ? ADDR_LO_STRAP1 : ADDR_LO_STRAP0};
    cmp("base", 34'(base), 34'(configPortBase));
    $display("test relocation done");
    @(posedge clk);
    cfgModeActive <= 1'b0;
    port(base + 16'h1, 1'b0, 8'h0);
    axRd(HREG_STATUS, {AXI_OKAY, 16'h0, FLOAT_BYTE, 8'h02});
    @(posedge clk);
    cfgModeActive <= 1'b1;
    port(base ^ 16'hf001, 1'b0, 8'h0);
    axRd(HREG_STATUS, {AXI_OKAY, 16'h0, FLOAT_BYTE, 8'h02});
    wrReg(IDX_OSC, 8'h04);
    base = base ^ 16'hf000;
    chkReg(IDX_CHIP_REV, REV);
    axWr(8'h10, 32'h0);
    axRd(8'h10, {AXI_SLVERR, 32'h0});
    $display("test mode and qualification done");
    close_out();
  end
endmodule // global_config_register_bank_test
